// ==== gdp_port.v ====
// IEEE-488 device port: handshakes, talker, listener, service request,
// remote/local, clear and trigger. Bus pins arrive unsynchronised and
// active low; open-collector outputs are an enable only (out held low).
// Notes on behaviour
// - Switch 1 on: addressable, obeys controller
// - Own address 1 to 30; 0 and 31 never addressed
// - Address is weights of off switches 4-8
// - Factory switches give address six
// - Switch 1 off at power-up: talk-only
// - Talk-only: button press starts measurement unless a result is pending
// - Talk-only: send result, flash listen lamp
// - Talk lamp while sending, always in talk-only
// - Full source handshake
// - Full acceptor handshake
// - Send only when talk-addressed or talk-only
// - Accept data only when listen-addressed
// - Can raise service request
// - Remote and local under bus control
// - Device clear restores factory defaults
// - Bus trigger starts measurement
// - No parallel poll, controller, extended addressing
// - Remote lamp while bus-controlled
// - Listen lamp while receiving
// - Lockout ignores push buttons
// - Status bit 6 set on request, poll clears
// - Trigger only in trigger-on-command modes
`include "gdp_port_consts.vh"
`default_nettype none
module gdp_port #(
    parameter integer FLASH_CYC = `GDP_FLASH_MS * 1000000 / `GDP_CLK_NS
) (
    input  wire       core_clk,
    input  wire       reset_n,
    input  wire [7:0] dip_sw,
    input  wire [7:0] dio_n_in,
    input  wire       atn_n_in,
    input  wire       eoi_n_in,
    input  wire       dav_n_in,
    input  wire       nrfd_n_in,
    input  wire       ndac_n_in,
    input  wire       ifc_n_in,
    input  wire       ren_n_in,
    output wire [7:0] dio_n_out,
    output reg  [7:0] dio_n_oe,
    output wire       eoi_n_out,
    output reg        eoi_n_oe,
    output wire       dav_n_out,
    output reg        dav_n_oe,
    output wire       nrfd_n_out,
    output reg        nrfd_n_oe,
    output wire       ndac_n_out,
    output reg        ndac_n_oe,
    output wire       srq_n_out,
    output wire       srq_n_oe,
    input  wire       button_press,
    input  wire       trig_on_get,
    input  wire       srq_request,
    input  wire [7:0] status_in,
    input  wire       meas_done,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    input  wire       tx_last,
    output wire       tx_ready,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output reg        rx_last,
    output reg        meas_start,
    output reg        dev_clear,
    output reg        talk_only,
    output wire [4:0] own_addr,
    output reg        lamp_remote,
    output wire       lamp_listen,
    output wire       lamp_talk,
    output reg        lamp_lockout,
    output reg        status_rsv
);
    localparam integer SETTLE_CYC = (`GDP_SETTLE_NS + `GDP_CLK_NS - 1) / `GDP_CLK_NS;
    localparam [1:0] SH_IDLE = 2'd0, SH_SETTLE = 2'd1, SH_DAV = 2'd2;
    localparam [1:0] AH_READY = 2'd0, AH_HOLD = 2'd1, AH_WAIT = 2'd2;
    function [4:0] sw_addr;
        input [7:0] sw;
        integer i;
        begin
            for (i = 0; i < 5; i = i + 1)
                sw_addr[4 - i] = ~sw[`GDP_ADR_BIT + i];
        end
    endfunction
    function cmd_is;
        input [6:0] cmd;
        input [6:0] code;
        begin
            cmd_is = (cmd == code);
        end
    endfunction
    // Two flops on every bus pin and switch; first stage read by nothing else
    reg [22:0] sync1_reg, sync2_reg;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 23'h7fffff;
            sync2_reg <= 23'h7fffff;
        end else begin
            sync1_reg <= {dip_sw, dio_n_in, atn_n_in, eoi_n_in, dav_n_in, nrfd_n_in,
                          ndac_n_in, ifc_n_in, ren_n_in};
            sync2_reg <= sync1_reg;
        end
    end
    wire [7:0] sw_s   = sync2_reg[22:15];
    wire [7:0] dio_s  = ~sync2_reg[14:7];
    wire       atn_s  = ~sync2_reg[6];
    wire       eoi_s  = ~sync2_reg[5];
    wire       dav_s  = ~sync2_reg[4];
    wire       nrfd_s = ~sync2_reg[3];
    wire       ndac_s = ~sync2_reg[2];
    wire       ifc_s  = ~sync2_reg[1];
    wire       ren_s  = ~sync2_reg[0];
    assign own_addr = sw_addr(sw_s);
    wire addr_ok = (own_addr != `GDP_ADDR_NONE);
    // mode caught once, after the synchroniser has filled
    reg [1:0]  boot_reg;
    reg [1:0]  sh_reg, ah_reg;
    reg        listen_reg, talk_reg, spe_reg, pend_reg, spoll_reg, sh_eoi_reg, cmd_stb;
    reg [31:0] flash_reg;
    reg [15:0] settle_reg;
    reg [7:0]  sh_byte_reg;
    reg [6:0]  cmd_reg;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_reg  <= 2'd0;
            talk_only <= 1'b0;
        end else if (boot_reg != 2'd3) begin
            boot_reg <= boot_reg + 2'd1;
            if (boot_reg == 2'd2)
                talk_only <= ~sw_s[`GDP_SW_ADDR_ON];
        end
    end

    wire cmd_mla = (cmd_reg & `GDP_CMD_MASK) == `GDP_CMD_LAG;
    wire cmd_mta = (cmd_reg & `GDP_CMD_MASK) == `GDP_CMD_TAG;
    wire mine    = addr_ok && (cmd_reg[4:0] == own_addr);
    // secondary addresses and parallel poll fall through unanswered
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            listen_reg   <= 1'b0;
            talk_reg     <= 1'b0;
            spe_reg      <= 1'b0;
            lamp_remote  <= 1'b0;
            lamp_lockout <= 1'b0;
            dev_clear    <= 1'b0;
            meas_start   <= 1'b0;
        end else begin
            dev_clear  <= 1'b0;
            meas_start <= 1'b0;
            if (ifc_s || talk_only) begin
                listen_reg <= 1'b0;
                talk_reg   <= 1'b0;
                spe_reg    <= ifc_s ? 1'b0 : spe_reg;
            end else if (cmd_stb) begin
                if (cmd_mla && mine) begin
                    listen_reg <= 1'b1;
                    if (ren_s)
                        lamp_remote <= 1'b1;
                end
                if (cmd_is(cmd_reg, `GDP_CMD_UNL))
                    listen_reg <= 1'b0;
                if (cmd_mta)
                    talk_reg <= mine;
                if (cmd_is(cmd_reg, `GDP_CMD_UNT))
                    talk_reg <= 1'b0;
                if (cmd_is(cmd_reg, `GDP_CMD_SPE))
                    spe_reg <= 1'b1;
                if (cmd_is(cmd_reg, `GDP_CMD_SPD))
                    spe_reg <= 1'b0;
                if (cmd_is(cmd_reg, `GDP_CMD_GTL) && listen_reg)
                    lamp_remote <= 1'b0;
                if (cmd_is(cmd_reg, `GDP_CMD_LLO) && ren_s)
                    lamp_lockout <= 1'b1;
                if (cmd_is(cmd_reg, `GDP_CMD_DCL) ||
                    (cmd_is(cmd_reg, `GDP_CMD_SDC) && listen_reg))
                    dev_clear <= 1'b1;
                if (cmd_is(cmd_reg, `GDP_CMD_GET) && listen_reg && trig_on_get)
                    meas_start <= 1'b1;
            end
            if (!ren_s) begin
                lamp_remote  <= 1'b0;
                lamp_lockout <= 1'b0;
            end
            if (button_press && !lamp_lockout && (talk_only ? !pend_reg : 1'b1))
                meas_start <= 1'b1;
        end
    end

    // result pending between reading and last byte
    wire sh_done = (sh_reg == SH_DAV) && !ndac_s;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_reg  <= 1'b0;
            flash_reg <= 32'd0;
        end else begin
            if (talk_only && meas_done)
                pend_reg <= 1'b1;
            else if (pend_reg && sh_done && sh_eoi_reg)
                pend_reg <= 1'b0;
            if (talk_only && pend_reg && sh_done && sh_eoi_reg)
                flash_reg <= FLASH_CYC;
            else if (flash_reg != 32'd0)
                flash_reg <= flash_reg - 32'd1;
        end
    end

    // source only when addressed or after a talk-only reading
    wire src_on  = !atn_s && ((talk_reg && !talk_only) || (talk_only && pend_reg));
    wire poll_on = src_on && talk_reg && spe_reg;
    assign tx_ready = (sh_reg == SH_IDLE) && src_on && !poll_on;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sh_reg      <= SH_IDLE;
            settle_reg  <= 16'd0;
            sh_byte_reg <= 8'h00;
            sh_eoi_reg  <= 1'b0;
            spoll_reg   <= 1'b0;
        end else begin
            case (sh_reg)
                SH_IDLE: begin
                    if (poll_on) begin
                        sh_byte_reg <= status_in;
                        sh_byte_reg[`GDP_RSV_BIT] <= status_rsv;
                        sh_eoi_reg  <= 1'b0;
                        spoll_reg   <= 1'b1;
                        settle_reg  <= SETTLE_CYC[15:0];
                        sh_reg      <= SH_SETTLE;
                    end else if (src_on && tx_valid) begin
                        sh_byte_reg <= tx_data;
                        sh_eoi_reg  <= tx_last;
                        spoll_reg   <= 1'b0;
                        settle_reg  <= SETTLE_CYC[15:0];
                        sh_reg      <= SH_SETTLE;
                    end
                end
                SH_SETTLE: begin
                    if (!src_on)
                        sh_reg <= SH_IDLE;
                    else if (settle_reg != 16'd0)
                        settle_reg <= settle_reg - 16'd1;
                    else if (!nrfd_s && ndac_s)
                        sh_reg <= SH_DAV;
                end
                SH_DAV: begin
                    // Attention from controller aborts the byte
                    if (!ndac_s || atn_s)
                        sh_reg <= SH_IDLE;
                end
                default: sh_reg <= SH_IDLE;
            endcase
        end
    end

    // request bit; set beats poll clear
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            status_rsv <= 1'b0;
        else if (srq_request)
            status_rsv <= 1'b1;
        else if (sh_done && spoll_reg)
            status_rsv <= 1'b0;
    end
    assign srq_n_out = 1'b0;
    assign srq_n_oe  = status_rsv;

    // acceptor: commands always, data only as listener
    wire acc_on = atn_s || (listen_reg && !talk_only);
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ah_reg   <= AH_READY;
            cmd_reg  <= 7'h00;
            cmd_stb  <= 1'b0;
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
            rx_last  <= 1'b0;
        end else begin
            cmd_stb  <= 1'b0;
            rx_valid <= 1'b0;
            case (ah_reg)
                AH_READY: begin
                    if (acc_on && dav_s) begin
                        if (atn_s) begin
                            cmd_reg <= dio_s[6:0];
                            cmd_stb <= 1'b1;
                        end else begin
                            rx_data  <= dio_s;
                            rx_last  <= eoi_s;
                            rx_valid <= 1'b1;
                        end
                        ah_reg <= AH_HOLD;
                    end
                end
                AH_HOLD: ah_reg <= AH_WAIT;
                AH_WAIT: begin
                    if (!dav_s)
                        ah_reg <= AH_READY;
                end
                default: ah_reg <= AH_READY;
            endcase
        end
    end

    // Open-collector drive: enable pulls the line low
    always @* begin
        dio_n_oe  = (sh_reg != SH_IDLE) ? sh_byte_reg : 8'h00;
        eoi_n_oe  = (sh_reg != SH_IDLE) && sh_eoi_reg;
        dav_n_oe  = (sh_reg == SH_DAV);
        nrfd_n_oe = acc_on && (ah_reg != AH_READY);
        ndac_n_oe = acc_on && (ah_reg != AH_WAIT);
    end
    assign dio_n_out  = 8'h00;
    assign eoi_n_out  = 1'b0;
    assign dav_n_out  = 1'b0;
    assign nrfd_n_out = 1'b0;
    assign ndac_n_out = 1'b0;

    // listen lamp, momentary flash in talk-only
    assign lamp_listen = listen_reg || (flash_reg != 32'd0);
    assign lamp_talk = talk_only || talk_reg;
endmodule
`default_nettype wire

// ==== gdp_port_consts.vh ====
// Constants for the instrument-side IEEE-488 port.
// Assumes a single 50 MHz core clock; included by gdp_port.v.
`ifndef GDP_PORT_CONSTS_VH
`define GDP_PORT_CONSTS_VH
`define GDP_CLK_NS       20
`define GDP_SETTLE_NS    2000
`define GDP_FLASH_MS     100
`define GDP_ADR_BIT      3
`define GDP_SW_ADDR_ON   0
`define GDP_CMD_MASK     7'h60
`define GDP_CMD_LAG      7'h20
`define GDP_CMD_TAG      7'h40
`define GDP_CMD_UNL      7'h3f
`define GDP_CMD_UNT      7'h5f
`define GDP_CMD_GTL      7'h01
`define GDP_CMD_SDC      7'h04
`define GDP_CMD_GET      7'h08
`define GDP_CMD_LLO      7'h11
`define GDP_CMD_DCL      7'h14
`define GDP_CMD_SPE      7'h18
`define GDP_CMD_SPD      7'h19
`define GDP_RSV_BIT      6
`define GDP_ADDR_NONE    5'h00
`endif

// ==== gdp_port_chk.sv ====
// Checker of the device port, bound to gdp_port.
// Assumes one clock domain; sees the top ports only.
`default_nettype none
module gdp_port_chk (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic [7:0] dip_sw,
    input wire logic [4:0] own_addr,
    input wire logic       talk_only,
    input wire logic       lamp_talk,
    input wire logic       srq_n_oe,
    input wire logic       srq_request,
    input wire logic       status_rsv,
    input wire logic [7:0] dio_n_oe,
    input wire logic       dav_n_oe,
    input wire logic       ndac_n_in,
    input wire logic       nrfd_n_oe,
    input wire logic       ndac_n_oe,
    input wire logic       rx_valid
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // Synchronisers hold reset values for a few edges
    logic [2:0] up_reg;
    always @(posedge core_clk or negedge reset_n)
        if (!reset_n)
            up_reg <= 3'h0;
        else if (up_reg != 3'h7)
            up_reg <= up_reg + 3'h1;
    a_addr_weights: assert property (
        $stable(dip_sw)[*3] ##0 up_reg == 3'h7 |->
        own_addr == ~{dip_sw[3], dip_sw[4], dip_sw[5], dip_sw[6], dip_sw[7]})
        else $error("address not from switches");
    a_mode_fixed: assert property (up_reg == 3'h7 |-> $stable(talk_only))
        else $error("mode changed without reset");
    a_talk_lamp: assert property (talk_only |-> lamp_talk)
        else $error("talk lamp dark");
    a_srq_pin: assert property (srq_n_oe == status_rsv)
        else $error("request line differs");
    a_rsv_cause: assert property ($rose(status_rsv) |-> $past(srq_request))
        else $error("request bit without cause");
    a_data_held: assert property (dav_n_oe |-> $stable(dio_n_oe))
        else $error("data moved under valid");
    a_dav_release: assert property (
        (dav_n_oe && ndac_n_in)[*4] |-> ##[0:2] !dav_n_oe)
        else $error("valid held after acceptance");
    a_ack_order: assert property (rx_valid |-> nrfd_n_oe ##1 !ndac_n_oe)
        else $error("acceptor order wrong");
    a_no_listen: assert property (talk_only |-> !nrfd_n_oe && !ndac_n_oe)
        else $error("talk-only unit accepting");
    c_rx: cover property (rx_valid);
    c_tx: cover property ($rose(dav_n_oe));
    c_rsv: cover property ($fell(status_rsv));
endmodule
bind gdp_port gdp_port_chk u_gdp_port_chk (.core_clk(core_clk), .reset_n(reset_n),
    .dip_sw(dip_sw), .own_addr(own_addr), .talk_only(talk_only), .lamp_talk(lamp_talk),
    .srq_n_oe(srq_n_oe), .srq_request(srq_request), .status_rsv(status_rsv),
    .dio_n_oe(dio_n_oe), .dav_n_oe(dav_n_oe), .ndac_n_in(ndac_n_in),
    .nrfd_n_oe(nrfd_n_oe), .ndac_n_oe(ndac_n_oe), .rx_valid(rx_valid));
`default_nettype wire

// ==== gdp_ctl_model.sv ====
// Controller and listen-only model on the far side of the port.
// Outputs are pulls (1 pulls low); the bench resolves the wires.
`default_nettype none
module gdp_ctl_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] dio_n,
    input  wire logic       dav_n,
    input  wire logic       nrfd_n,
    input  wire logic       ndac_n,
    output var  logic       c_atn,
    output var  logic       c_dav,
    output var  logic [7:0] c_dio,
    output var  logic       c_nrfd,
    output var  logic       c_ndac
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       listen_on = 1'b0;
    logic [7:0] got_byte  = 8'h00;
    int         got_cnt   = 0;
    int         slow      = 0;
    initial begin
        c_atn = 1'b0;
        c_dav = 1'b0;
        c_dio = 8'h00;
        c_nrfd = 1'b0;
        c_ndac = 1'b0;
    end
    task automatic send(input logic atn, input logic [7:0] b, output logic ok);
        int n;
        n = 0;
        c_atn = atn;
        c_dio = b;
        while ((!nrfd_n || ndac_n) && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        ok = n < 400;
        repeat (4 + slow) @(negedge core_clk);
        c_dav = ok;
        while (c_dav && !ndac_n && n < 800) begin
            @(negedge core_clk);
            n++;
        end
        c_dav = 1'b0;
        c_dio = 8'h00;
        c_atn = 1'b0;
        @(negedge core_clk);
    endtask
    always @(negedge core_clk)
        if (!listen_on) begin
            c_nrfd <= 1'b0;
            c_ndac <= 1'b0;
        end else if (!dav_n && c_ndac) begin
            got_byte <= ~dio_n;
            got_cnt <= got_cnt + 1;
            c_nrfd <= 1'b1;
            c_ndac <= 1'b0;
        end else if (dav_n) begin
            c_nrfd <= 1'b0;
            c_ndac <= 1'b1;
        end
endmodule
`default_nettype wire

// ==== gdp_port_tb.sv ====
// Bench of the device port against the controller model.
// Assumes the port, its checker and the model compile first.
`default_nettype none
module gdp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, reset_n = 1'b0, ren_n_in = 1'b1, ok;
    logic button_press = 1'b0, trig_on_get = 1'b0, srq_request = 1'b0;
    logic meas_done = 1'b0, tx_valid = 1'b0, tx_last = 1'b0;
    logic [7:0] dip_sw = 8'h9f, tx_data = 8'h00, rx_byte;
    wire logic [7:0] dio_n_oe, c_dio, rx_data;
    wire logic [4:0] own_addr;
    wire logic eoi_n_oe, dav_n_oe, nrfd_n_oe, ndac_n_oe, srq_n_oe, tx_ready, c_atn, c_dav;
    wire logic c_nrfd, c_ndac, rx_valid, rx_last, meas_start, dev_clear, talk_only, status_rsv;
    wire logic lamp_remote, lamp_listen, lamp_talk, lamp_lockout;
    wire logic [7:0] dio_n = ~(c_dio | dio_n_oe);
    wire logic dav_n = ~(c_dav | dav_n_oe);
    wire logic nrfd_n = ~(c_nrfd | nrfd_n_oe);
    wire logic ndac_n = ~(c_ndac | ndac_n_oe);
    int errors = 0, compares = 0, cyc = 0, n_meas = 0, n_clr = 0, n0;
    logic [12:0] rows [4] = '{{8'h7f, 5'h01}, {8'hf7, 5'h10}, {8'h07, 5'h1f}, {8'h9f, 5'h06}};
    gdp_port #(.FLASH_CYC(20)) u_gdp_port (.core_clk(core_clk), .reset_n(reset_n),
        .dip_sw(dip_sw), .dio_n_in(dio_n), .atn_n_in(~c_atn), .eoi_n_in(~eoi_n_oe),
        .dav_n_in(dav_n), .nrfd_n_in(nrfd_n), .ndac_n_in(ndac_n), .ifc_n_in(1'b1),
        .ren_n_in(ren_n_in), .dio_n_out(), .dio_n_oe(dio_n_oe), .eoi_n_out(),
        .eoi_n_oe(eoi_n_oe), .dav_n_out(), .dav_n_oe(dav_n_oe), .nrfd_n_out(),
        .nrfd_n_oe(nrfd_n_oe), .ndac_n_out(), .ndac_n_oe(ndac_n_oe), .srq_n_out(),
        .srq_n_oe(srq_n_oe), .button_press(button_press), .trig_on_get(trig_on_get),
        .srq_request(srq_request), .status_in(8'h08), .meas_done(meas_done),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .meas_start(meas_start),
        .dev_clear(dev_clear), .talk_only(talk_only), .own_addr(own_addr),
        .lamp_remote(lamp_remote), .lamp_listen(lamp_listen), .lamp_talk(lamp_talk),
        .lamp_lockout(lamp_lockout), .status_rsv(status_rsv));
    gdp_ctl_model u_gdp_ctl_model (.core_clk(core_clk), .dio_n(dio_n), .dav_n(dav_n),
        .nrfd_n(nrfd_n), .ndac_n(ndac_n), .c_atn(c_atn), .c_dav(c_dav), .c_dio(c_dio),
        .c_nrfd(c_nrfd), .c_ndac(c_ndac));
    always #10 core_clk = ~core_clk;
    task end_of_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task cmd(input logic [7:0] b);
        u_gdp_ctl_model.send(1'b1, b, ok);
        chk1(ok, 1'b1);
    endtask
    task take(input logic [7:0] exp);
        n0 = u_gdp_ctl_model.got_cnt;
        u_gdp_ctl_model.listen_on = 1'b1;
        for (int k = 0; k < 400 && u_gdp_ctl_model.got_cnt == n0; k++)
            @(negedge core_clk);
        chk8(u_gdp_ctl_model.got_byte, exp);
        repeat (8) @(negedge core_clk);
        u_gdp_ctl_model.listen_on = 1'b0;
    endtask
    task pulse_btn;
        n0 = n_meas;
        button_press = 1'b1;
        @(negedge core_clk);
        button_press = 1'b0;
    endtask
    // Hang guard: whole run needs about a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        n_meas += meas_start;
        n_clr += dev_clear;
        if (rx_valid)
            rx_byte <= rx_data;
        if (cyc == 30000) begin
            errors++;
            end_of_test;
        end
    end
    initial begin
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge core_clk);
        chk1(talk_only | lamp_remote, 1'b0);
        for (int i = 0; i < 4; i++) begin
            dip_sw = rows[i][12:5];
            repeat (4) @(negedge core_clk);
            chk8({3'h0, own_addr}, {3'h0, rows[i][4:0]});
        end
        ren_n_in = 1'b0;
        cmd(8'h26);
        chk1(lamp_remote & lamp_listen, 1'b1);
        u_gdp_ctl_model.send(1'b0, 8'ha5, ok);
        chk8(rx_byte, 8'ha5);
        chk1(rx_last, 1'b0);
        cmd(8'h3f);
        cmd(8'h25);
        u_gdp_ctl_model.send(1'b0, 8'h5a, ok);
        chk1(ok, 1'b0);
        cmd(8'h26);
        cmd(8'h11);
        chk1(lamp_lockout, 1'b1);
        pulse_btn;
        cmd(8'h08);
        trig_on_get = 1'b1;
        cmd(8'h08);
        repeat (4) @(negedge core_clk);
        chk8(8'(n_meas - n0), 8'h01);
        cmd(8'h14);
        chk8(8'(n_clr), 8'h01);
        ren_n_in = 1'b1;
        repeat (4) @(negedge core_clk);
        chk1(lamp_lockout | lamp_remote, 1'b0);
        srq_request = 1'b1;
        @(negedge core_clk);
        srq_request = 1'b0;
        @(negedge core_clk);
        chk1(srq_n_oe, 1'b1);
        cmd(8'h3f);
        cmd(8'h18);
        cmd(8'h46);
        take(8'h48);
        chk1(lamp_talk, 1'b1);
        chk1(status_rsv, 1'b0);
        cmd(8'h19);
        reset_n = 1'b0;
        dip_sw = 8'h9e;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge core_clk);
        chk1(talk_only & lamp_talk, 1'b1);
        pulse_btn;
        repeat (4) @(negedge core_clk);
        chk8(8'(n_meas - n0), 8'h01);
        meas_done = 1'b1;
        @(negedge core_clk);
        meas_done = 1'b0;
        tx_data = 8'h3c;
        tx_last = 1'b1;
        tx_valid = 1'b1;
        for (int k = 0; k < 50 && !tx_ready; k++)
            @(negedge core_clk);
        @(negedge core_clk);
        tx_valid = 1'b0;
        take(8'h3c);
        chk1(lamp_listen, 1'b1);
        repeat (30) @(negedge core_clk);
        chk1(lamp_listen, 1'b0);
        end_of_test;
    end
endmodule
`default_nettype wire
